// >>> design/pbcl_loader.v
`timescale 1ns/1ps
`include "pbcl_map.vh"
module pbcl_loader #(
   parameter [31:0] SLOT_SHORT_CYC = `PBCL_SLOT_SHORT_CYC,
   parameter [31:0] SLOT_LONG_CYC = `PBCL_SLOT_LONG_CYC,
   parameter [35:0] WDT_CYC = `PBCL_WDT_CYC
)
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire boot_source_pin,
   input wire [16:0] eeprom_cfg,
   input wire [7:0] eeprom_version,
   input wire power_button_in,
   input wire hold_on_input,
   input wire warm_reset_in,
   input wire irq_event,
   input wire [1:0] gp_pin4_5_in,
   input wire supply_high_event,
   input wire gp_pin0_value,
   output reg boot_pin_enable,
   output reg irq_out,
   output reg gp_pin0_out,
   output reg gp_pin0_oe,
   output reg rtc_ldo_off_fullpower,
   output reg slow_clock_source_sel,
   output reg sense_buffer_bypass,
   output reg power_on,
   output reg sequence_active,
   output reg [3:0] sequence_slot,
   output reg warm_reset_req,
   output reg core_reset_req,
   output reg longpress_off_req,
   output reg wdt_expired,
   output reg hold_pin_gpi
);
   // Loader states
   localparam ST_SAMPLE = 2'b00;
   localparam ST_LOAD = 2'b01;
   localparam ST_SEQ = 2'b10;
   localparam ST_RUN = 2'b11;
   reg [1:0] state; // Loader state
   reg [16:0] cfg; // Live configuration bits
   reg [7:0] seq_version_field; // Loaded sequence version
   reg boot_mode; // Latched boot source
   reg [31:0] slot_cnt; // Slot timer
   reg [35:0] wdt_cnt; // Watchdog timer
   reg keep_on_request; // Effective keep-on bit
   reg [1:0] gp_prev; // Previous pin 4/5 levels
   reg ph_valid; // Data phase pending
   reg ph_write; // Pending is a write
   reg [7:0] ph_addr; // Pending address
   reg lp_cnt_done; // Long press seen
   reg [31:0] lp_cnt; // Long press counter
   wire [31:0] slot_len;
   wire [1:0] gp_rise;
   wire [1:0] gp_fall;
   wire irq_active;
   wire warm_active;
   wire addr_ok;

   // Slot length from selected duration
   assign slot_len = cfg[`PBCL_B_SLOT] ? SLOT_LONG_CYC : SLOT_SHORT_CYC;
   assign gp_rise = gp_pin4_5_in & ~gp_prev;
   assign gp_fall = ~gp_pin4_5_in & gp_prev;
   // Interrupt sources, pin 4/5 edges masked per bit (0 unmasks), irq_event never masked
   assign irq_active = irq_event | (gp_rise[0] & ~cfg[`PBCL_B_G4R]) | (gp_fall[0] & ~cfg[`PBCL_B_G4F]) |
      (gp_rise[1] & ~cfg[`PBCL_B_G5R]) | (gp_fall[1] & ~cfg[`PBCL_B_G5F]);
   // Warm reset level after polarity
   assign warm_active = cfg[`PBCL_B_WRPOL] ? warm_reset_in : ~warm_reset_in;
   assign addr_ok = (haddr[7:0] == `PBCL_CFG_OFS) || (haddr[7:0] == `PBCL_STAT_OFS) ||
      (haddr[7:0] == `PBCL_VER_OFS) || (haddr[7:0] == `PBCL_EE_OFS);

   // Boot load, sequencer and register writes
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= ST_SAMPLE;
         cfg <= `PBCL_FIXED_CFG;
         seq_version_field <= `PBCL_FIXED_VER;
         boot_mode <= 1'b0;
         boot_pin_enable <= 1'b1;
         slot_cnt <= 32'h0;
         sequence_slot <= 4'h0;
         sequence_active <= 1'b0;
         power_on <= 1'b0;
         keep_on_request <= 1'b0;
      end
      else
      begin
         case (state)
            ST_SAMPLE:
            begin
               // Catch boot pin once after reset release
               boot_mode <= boot_source_pin;
               boot_pin_enable <= 1'b0;
               state <= ST_LOAD;
            end
            ST_LOAD:
            begin
               // Stored boot loads cfg and version in the same cycle as slot one begins, keep-on request cleared
               if (boot_mode)
               begin
                  cfg <= eeprom_cfg;
                  seq_version_field <= eeprom_version;
               end
               keep_on_request <= 1'b0;
               slot_cnt <= 32'h0;
               sequence_slot <= 4'h1;
               sequence_active <= 1'b1;
               state <= ST_SEQ;
            end
            ST_SEQ:
            begin
               // Fifteen consecutive slots
               if (slot_cnt >= slot_len - 32'h1)
               begin
                  slot_cnt <= 32'h0;
                  if (sequence_slot == `PBCL_NUM_SLOTS)
                  begin
                     sequence_active <= 1'b0;
                     power_on <= 1'b1;
                     // Auto keep-on sets the request in the same cycle as power-on
                     if (cfg[`PBCL_B_AUTO])
                        keep_on_request <= 1'b1;
                     state <= ST_RUN;
                  end
                  else
                     sequence_slot <= sequence_slot + 4'h1;
               end
               else
                  slot_cnt <= slot_cnt + 32'h1;
            end
            ST_RUN:
            begin
               // Stay on while keep-on, hold pin (auto keep-on clear only) or unmasked supply wake
               if (keep_on_request || (!cfg[`PBCL_B_AUTO] && hold_on_input))
                  power_on <= 1'b1;
               else if (supply_high_event && !cfg[`PBCL_B_SUPMSK])
                  power_on <= 1'b1;
               else if (longpress_off_req)
                  power_on <= 1'b0;
               else
                  power_on <= power_on;
            end
            default:
               state <= ST_SAMPLE;
         endcase
         // Software may overwrite the loaded configuration, not the version
         if (ph_valid && ph_write && ph_addr == `PBCL_CFG_OFS && state != ST_SAMPLE)
         begin
            cfg <= hwdata[16:0];
            keep_on_request <= hwdata[`PBCL_B_KEEP];
         end
      end
   end

   // Long press detection, low level on button, counter saturates at SLOT_LONG_CYC
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lp_cnt <= 32'h0;
         lp_cnt_done <= 1'b0;
         longpress_off_req <= 1'b0;
         core_reset_req <= 1'b0;
      end
      else
      begin
         if (power_button_in)
         begin
            lp_cnt <= 32'h0;
            lp_cnt_done <= 1'b0;
         end
         else if (lp_cnt >= SLOT_LONG_CYC)
            lp_cnt_done <= 1'b1;
         else
            lp_cnt <= lp_cnt + 32'h1;
         longpress_off_req <= lp_cnt_done & cfg[`PBCL_B_LPOFF] & ~keep_on_request;
         core_reset_req <= lp_cnt_done & cfg[`PBCL_B_LPRST] & ~power_on;
      end
   end

   // Watchdog, pins and outputs
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wdt_cnt <= 36'h0;
         wdt_expired <= 1'b0;
         gp_prev <= 2'b00;
         irq_out <= 1'b1;
         gp_pin0_out <= 1'b0;
         gp_pin0_oe <= 1'b0;
         rtc_ldo_off_fullpower <= 1'b0;
         slow_clock_source_sel <= 1'b0;
         sense_buffer_bypass <= 1'b0;
         warm_reset_req <= 1'b0;
         hold_pin_gpi <= 1'b0;
      end
      else
      begin
         // Periodic watchdog when enabled
         if (!cfg[`PBCL_B_WDT] || state != ST_RUN)
         begin
            wdt_cnt <= 36'h0;
            wdt_expired <= 1'b0;
         end
         else if (wdt_cnt >= WDT_CYC - 36'h1)
         begin
            wdt_cnt <= 36'h0;
            wdt_expired <= 1'b1;
         end
         else
         begin
            wdt_cnt <= wdt_cnt + 36'h1;
            wdt_expired <= 1'b0;
         end
         gp_prev <= gp_pin4_5_in;
         irq_out <= cfg[`PBCL_B_IRQPOL] ? irq_active : ~irq_active;
         hold_pin_gpi <= cfg[`PBCL_B_AUTO];
         // Open drain drives only the low level
         if (cfg[`PBCL_B_ODEN])
         begin
            gp_pin0_out <= 1'b0;
            gp_pin0_oe <= ~gp_pin0_value;
         end
         else
         begin
            gp_pin0_out <= gp_pin0_value;
            gp_pin0_oe <= 1'b1;
         end
         rtc_ldo_off_fullpower <= cfg[`PBCL_B_RTC];
         slow_clock_source_sel <= cfg[`PBCL_B_CLK];
         sense_buffer_bypass <= cfg[`PBCL_B_BYP];
         warm_reset_req <= warm_active;
      end
   end

   // AHB-Lite slave, zero wait states
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready)
         begin
            ph_valid <= hsel & htrans[1] & addr_ok;
            ph_write <= hwrite;
            ph_addr <= haddr[7:0];
            // Read data ready for the data phase
            if (hsel && htrans[1] && !hwrite)
            begin
               case (haddr[7:0])
                  `PBCL_CFG_OFS: hrdata <= {15'h0, cfg[16:3], keep_on_request, cfg[1:0]};
                  `PBCL_STAT_OFS: hrdata <= {22'h0, boot_mode, wdt_expired, sequence_slot, state, sequence_active,
                     power_on};
                  `PBCL_VER_OFS: hrdata <= {24'h0, seq_version_field};
                  `PBCL_EE_OFS: hrdata <= {15'h0, eeprom_cfg};
                  default: hrdata <= 32'h0;
               endcase
            end
         end
      end
   end
endmodule

// >>> design/pbcl_map.vh
`ifndef PBCL_MAP_VH
`define PBCL_MAP_VH
// Register byte offsets
`define PBCL_CFG_OFS 8'h00
`define PBCL_STAT_OFS 8'h04
`define PBCL_VER_OFS 8'h08
`define PBCL_EE_OFS 8'h0c
// Configuration field positions
`define PBCL_B_RTC 0
`define PBCL_B_CLK 1
`define PBCL_B_KEEP 2
`define PBCL_B_SLOT 3
`define PBCL_B_LPOFF 4
`define PBCL_B_LPRST 5
`define PBCL_B_IRQPOL 6
`define PBCL_B_SUPMSK 7
`define PBCL_B_G4R 8
`define PBCL_B_G4F 9
`define PBCL_B_G5R 10
`define PBCL_B_G5F 11
`define PBCL_B_ODEN 12
`define PBCL_B_WDT 13
`define PBCL_B_BYP 14
`define PBCL_B_AUTO 15
`define PBCL_B_WRPOL 16
`define PBCL_CFG_W 17
// Fixed boot defaults
`define PBCL_FIXED_CFG 17'h0eab8
`define PBCL_FIXED_VER 8'h00
// Timing
`define PBCL_CLK_MHZ 50
`define PBCL_SLOT_SHORT_US 500
`define PBCL_SLOT_LONG_US 2000
`define PBCL_SLOT_SHORT_CYC 32'h000061a8
`define PBCL_SLOT_LONG_CYC 32'h000186a0
`define PBCL_WDT_S 100
`define PBCL_WDT_CYC 36'h12a05f200
`define PBCL_NUM_SLOTS 4'hf
`endif

// >>> testbench/pbcl_asserts.sv
`timescale 1ns/1ps
module pbcl_asserts #(
   parameter [35:0] WDT_CYC = 64
)
(
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire boot_pin_enable,
   input wire sequence_active,
   input wire [3:0] sequence_slot,
   input wire wdt_expired
);
   // Quiet span between watchdog pulses
   localparam int WDT_GAP = WDT_CYC - 2;
   // Cycles since reset release, saturating
   reg [1:0] since_rst;
   // Count up to three after reset
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         since_rst <= 2'h0;
      else if (since_rst != 2'h3)
         since_rst <= since_rst + 2'h1;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A slot stays put for the shortest slot length
   sequence s_slot_held;
      $stable(sequence_slot) [*3];
   endsequence
   sequence s_slot_moved;
      sequence_active && $changed(sequence_slot);
   endsequence
   AST_READY: assert property (hreadyout) else $error("wait state inserted");
   AST_OKAY: assert property (!hresp) else $error("error response seen");
   AST_BOOT_OFF: assert property (since_rst == 2'h3 |-> !boot_pin_enable)
      else $error("boot pin still enabled");
   AST_SLOT_RANGE: assert property (sequence_active |-> sequence_slot inside {[4'h1:4'hf]})
      else $error("slot number out of range");
   AST_SLOT_FIRST: assert property ($rose(sequence_active) |-> sequence_slot == 4'h1)
      else $error("sequence did not start at slot one");
   AST_SLOT_STEP: assert property (s_slot_moved |-> sequence_slot == $past(sequence_slot) + 4'h1)
      else $error("slot skipped");
   AST_SLOT_HOLD: assert property (s_slot_moved |=> s_slot_held)
      else $error("slot too short");
   AST_WDT_PERIOD: assert property (wdt_expired |=> not (##[0:WDT_GAP] wdt_expired))
      else $error("watchdog pulses too close");
endmodule
bind pbcl_loader pbcl_asserts #(.WDT_CYC(WDT_CYC)) u_pbcl_asserts (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .boot_pin_enable(boot_pin_enable),
   .sequence_active(sequence_active), .sequence_slot(sequence_slot), .wdt_expired(wdt_expired));

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`include "pbcl_map.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module testbench;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, boot_source_pin = 0, hold_on_input = 0, irq_event = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0] htrans = 0;
   logic power_button_in = 1, warm_reset_in = 1, supply_high_event = 0, gp_pin0_value = 0;
   logic [1:0] gp_pin4_5_in = 0;
   wire gp_pin0_out, gp_pin0_oe, power_on, warm_reset_req, core_reset_req, longpress_off_req;
   logic [16:0] eeprom_cfg = 17'h02003;
   logic [7:0] eeprom_version = 8'h5c; // Arbitrary version code
   wire [31:0] hrdata;
   wire [3:0] sequence_slot;
   wire hreadyout, hresp, boot_pin_enable, irq_out, rtc_ldo_off_fullpower, slow_clock_source_sel;
   wire sense_buffer_bypass, sequence_active, wdt_expired, hold_pin_gpi;
   int compares = 0, miscompares = 0;
   pbcl_loader #(.SLOT_SHORT_CYC(4), .SLOT_LONG_CYC(16), .WDT_CYC(64)) u_pbcl_loader (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .boot_source_pin(boot_source_pin), .eeprom_cfg(eeprom_cfg), .eeprom_version(eeprom_version),
      .power_button_in(power_button_in), .hold_on_input(hold_on_input), .warm_reset_in(warm_reset_in),
      .irq_event(irq_event), .gp_pin4_5_in(gp_pin4_5_in), .supply_high_event(supply_high_event),
      .gp_pin0_value(gp_pin0_value), .boot_pin_enable(boot_pin_enable),
      .irq_out(irq_out), .gp_pin0_out(gp_pin0_out), .gp_pin0_oe(gp_pin0_oe),
      .rtc_ldo_off_fullpower(rtc_ldo_off_fullpower), .slow_clock_source_sel(slow_clock_source_sel),
      .sense_buffer_bypass(sense_buffer_bypass), .power_on(power_on),
      .sequence_active(sequence_active), .sequence_slot(sequence_slot), .warm_reset_req(warm_reset_req),
      .core_reset_req(core_reset_req), .longpress_off_req(longpress_off_req), .wdt_expired(wdt_expired),
      .hold_pin_gpi(hold_pin_gpi));
   // Free running 50 MHz clock
   initial
   begin
      forever #10 hclk = ~hclk;
   end
   // One single AHB-Lite word transfer, held until hready
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Reset for six cycles with the chosen boot source
   task rst(input logic b);
      @(posedge hclk);
      hresetn <= 0;
      boot_source_pin <= b;
      repeat (6) @(posedge hclk);
      hresetn <= 1;
      // Return after the boot pin edge, before slot one starts
      @(posedge hclk);
   endtask
   // Count watchdog pulses over four periods
   task wdt_count(input int e);
      int n;
      n = 0;
      repeat (256) begin @(negedge hclk); n += (wdt_expired === 1'b1); end
      `CHK(n >= e - 1 && n <= e, 1'b1)
   endtask
   // One pin 4/5 step, then the interrupt level it leaves
   task gp_step(input logic [1:0] v, input logic e);
      @(posedge hclk);
      gp_pin4_5_in <= v;
      repeat (2) @(negedge hclk);
      `CHK(irq_out, e)
   endtask
   // Fixed boot defaults and interrupt polarity
   task t_fixed;
      rst(0);
      ahb(0, `PBCL_CFG_OFS, 0);
      `CHK(rd, 32'h0000eab8)
      ahb(0, `PBCL_VER_OFS, 0);
      `CHK(rd[7:0], `PBCL_FIXED_VER)
      `CHK({rtc_ldo_off_fullpower, slow_clock_source_sel, sense_buffer_bypass, hold_pin_gpi}, 4'h3)
      `CHK({boot_pin_enable, irq_out}, 2'h1)
      `CHK({warm_reset_req, gp_pin0_out, gp_pin0_oe}, 3'h1)
      irq_event <= 1;
      repeat (4) @(negedge hclk);
      `CHK(irq_out, 1'b0)
      @(posedge hclk);
      irq_event <= 0;
      gp_step(2'h1, 1'b0);
      gp_step(2'h0, 1'b1);
      gp_step(2'h2, 1'b0);
      gp_step(2'h0, 1'b1);
      $display("t_fixed done");
   endtask
   // Stored boot image, both slot lengths, watchdog running
   task t_stored;
      int n;
      for (int s = 0; s < 2; s++) begin
         eeprom_cfg <= 17'h02003 | (s << 3);
         hold_on_input <= 1;
         rst(1);
         n = 0;
         repeat (300) begin @(negedge hclk); n += (sequence_active === 1'b1); end
         `CHK(n, s ? 240 : 60)
         ahb(0, `PBCL_CFG_OFS, 0);
         `CHK(rd, {15'h0, eeprom_cfg})
         `CHK({rtc_ldo_off_fullpower, slow_clock_source_sel, sense_buffer_bypass, hold_pin_gpi}, 4'hc)
      end
      ahb(0, `PBCL_VER_OFS, 0);
      `CHK(rd[7:0], eeprom_version)
      wdt_count(4);
      $display("t_stored done");
   endtask
   // Software overwrite, read-only and unmapped places
   task t_write;
      ahb(1, `PBCL_CFG_OFS, 32'h0001d0c3);
      ahb(1, `PBCL_VER_OFS, 32'h000000ff);
      ahb(1, 32'h00000010, 32'h12345678);
      ahb(0, `PBCL_CFG_OFS, 0);
      `CHK(rd, 32'h0001d0c3)
      ahb(0, `PBCL_VER_OFS, 0);
      `CHK(rd[7:0], eeprom_version)
      ahb(0, 32'h00000010, 0);
      `CHK(rd, 32'h0)
      `CHK({rtc_ldo_off_fullpower, slow_clock_source_sel, sense_buffer_bypass, hold_pin_gpi}, 4'hf)
      irq_event <= 1;
      repeat (4) @(negedge hclk);
      `CHK(irq_out, 1'b1)
      @(posedge hclk);
      irq_event <= 0;
      repeat (4) @(negedge hclk);
      `CHK(irq_out, 1'b0)
      wdt_count(0);
      $display("t_write done");
   endtask
   // Long press, supply wake mask, warm reset polarity and open drain
   task t_press;
      ahb(1, `PBCL_CFG_OFS, 32'h00011ab0);
      hold_on_input <= 0;
      repeat (2) @(negedge hclk);
      `CHK({power_on, warm_reset_req, gp_pin0_out, gp_pin0_oe}, 4'hd)
      @(posedge hclk);
      gp_pin0_value <= 1;
      warm_reset_in <= 0;
      power_button_in <= 0;
      repeat (24) @(negedge hclk);
      `CHK({longpress_off_req, power_on, core_reset_req, warm_reset_req, gp_pin0_oe}, 5'h14)
      @(posedge hclk);
      power_button_in <= 1;
      supply_high_event <= 1;
      @(posedge hclk);
      supply_high_event <= 0;
      repeat (3) @(negedge hclk);
      `CHK({longpress_off_req, power_on}, 2'h0)
      ahb(1, `PBCL_CFG_OFS, 32'h00011a30);
      @(posedge hclk);
      supply_high_event <= 1;
      @(posedge hclk);
      supply_high_event <= 0;
      repeat (2) @(negedge hclk);
      `CHK(power_on, 1'b1)
      $display("t_press done");
   endtask
   // Verdict and end of run
   task test_done;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      #400000;
      miscompares++;
      test_done;
   end
   // Main sequence
   initial
   begin
      t_fixed;
      t_stored;
      t_write;
      t_press;
      test_done;
   end
endmodule
